// File: rtl/epo_regs.svh
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH
// Notes on behaviour
// - The second pulse pin carries apparent energy pulses when its select field is 01.
// - The third pulse pin carries apparent energy pulses when its select field is 11.
// - Apparent pulse rate follows apparent power magnitude; full scale gives the scale rate.
// - Pulse rate is the scale value times the divided clock over 2048.
// - Apparent pulses never come faster than the divided clock over 2048.
// - A pin carrying apparent pulses has no energy direction indication.
// - With the third select at 00, the reset value, the third pin carries reactive pulses.
// - Reactive sign is the second pin level at the third pin falling edge, high positive.
// - Reactive pulse rate follows reactive power magnitude; full scale gives the scale rate.
// - Third select 10 makes the third pin high for positive and low for negative voltage.
// - Third select 01 makes the third pin follow the supply threshold comparator.
// - Second select: 00 energy sign, 01 apparent energy, 10 tamper, 11 reserved.
// - The first pin pulses low at a rate set by active power; the second pin gives sign.
// - Each pulse lasts one output word period, 1024 divided clock cycles.
// - A divide field of 0000 divides the clock by 16.

// Register byte addresses
`define EPO_ADDR_MODE 12'h000
`define EPO_ADDR_RATE 12'h004
`define EPO_ADDR_DIV 12'h008
`define EPO_ADDR_STAT 12'h00C

// Mode register fields
`define EPO_SEL2_LSB 0
`define EPO_SEL3_LSB 2

// Reset values
`define EPO_RATE_RST 24'h400000
`define EPO_DIV_RST 4'h1

// Divider: a field of zero gives the last count of a divide by 16
`define EPO_DIV_ZERO 4'h0
`define EPO_DIV_ZERO_LAST 4'hF
`define EPO_DIV_ONE 4'h1
`define EPO_DIV_ZERO_RATIO 16

// One output word is 1024 divided clock cycles
`define EPO_WORD_LEN 1024
`define EPO_WORD_LAST 10'h3FF

// Accumulator: full scale power times full rate is 2^24, a pulse fires at 2^25
`define EPO_ACC_THRESH 26'h2000000
`define EPO_MAG_SAT 24'hFFFFFE
`define EPO_SIGNED_MIN 24'h800000

// Status register width
`define EPO_STAT_W 7

`endif

// File: rtl/epo_pkg.sv
package epo_pkg;

    // Second pin functions
    typedef enum logic [1:0] {
        EPO_S2_SIGN = 2'h0,
        EPO_S2_APPARENT = 2'h1,
        EPO_S2_TAMPER = 2'h2,
        EPO_S2_RESERVED = 2'h3
    } epo_sel2_type;

    // Third pin functions
    typedef enum logic [1:0] {
        EPO_S3_REACTIVE = 2'h0,
        EPO_S3_SUPPLY = 2'h1,
        EPO_S3_VSIGN = 2'h2,
        EPO_S3_APPARENT = 2'h3
    } epo_sel3_type;

    // Pulse generator state
    typedef struct packed {
        logic [25:0] acc;
        logic pulse;
    } epo_pg_state_type;

    // Top level state
    typedef struct packed {
        epo_sel2_type sel2;
        epo_sel3_type sel3;
        logic [23:0] rate;
        logic [3:0] div_k;
        logic [3:0] div_cnt;
        logic [9:0] word_cnt;
        logic settle2;
        logic settle3;
        logic sign;
        logic first;
        logic second;
        logic third;
        logic cmp_meta;
        logic cmp_sync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] ticks_since;
        logic [14:0] low_cnt;
        logic react_neg;
    } epo_state_type;

endpackage

// File: rtl/epo_pulse_gen.sv
`timescale 1ns/100ps
`include "epo_regs.svh"

module epo_pulse_gen
    import epo_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic word_tick,
    input wire logic clear,
    input wire logic allow,
    // Power magnitude and scale
    input wire logic [23:0] magnitude,
    input wire logic [23:0] rate,
    // Result
    output logic due,
    output logic pulse
);

    epo_pg_state_type s_q;
    epo_pg_state_type s_d;
    logic [47:0] prod;
    logic [25:0] sum;

    // Accumulate scaled magnitude once per output word
    always_comb
    begin
        prod = magnitude * rate;
        sum = s_q.acc + {2'b00, prod[47:24]};
        // No fire while a pulse is out, so pulses keep at least one word apart
        due = (sum >= `EPO_ACC_THRESH) && !s_q.pulse;
        s_d = s_q;
        if (word_tick)
        begin
            s_d.pulse = 1'b0;
            if (due && allow && !clear)
            begin
                s_d.pulse = 1'b1;
                s_d.acc = sum - `EPO_ACC_THRESH;
            end
            else if (s_q.acc < `EPO_ACC_THRESH)
            begin
                // Stop adding once over threshold; a deferred pulse loses little
                s_d.acc = sum;
            end
        end
        if (clear)
        begin
            s_d.acc = '0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.pulse;

    sequence word_fire;
        word_tick && due && allow && !clear;
    endsequence

    chk_pulse_from_acc: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.pulse) |-> $past(word_tick) && $past(due))
        else $error("pulse started without an accumulator crossing");

    chk_fire_sets_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        word_fire |=> s_q.pulse)
        else $error("accumulator crossing did not start a pulse");

endmodule

// File: rtl/epo_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "epo_regs.svh"

module epo_top
    import epo_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement results, same clock
    input wire logic [23:0] active_power,
    input wire logic [23:0] reactive_power,
    input wire logic [23:0] apparent_power,
    input wire logic line_voltage_negative,
    input wire logic tamper_detected,
    // Comparator pin, asynchronous
    input wire logic supply_threshold_compare,
    // Pulse pins, active low
    output logic first_pulse_pin,
    output logic second_pulse_pin,
    output logic third_pulse_pin
);

    epo_state_type s_q;
    epo_state_type s_d;

    logic [3:0] div_last;
    logic dclk_tick;
    logic word_tick;
    logic access;
    logic commit;
    logic addr_ok;
    logic [23:0] pwr [3];
    logic [23:0] mag [3];
    logic [2:0] due;
    logic [2:0] pulse;
    logic [2:0] allow;
    logic [2:0] clear;
    logic [`EPO_STAT_W-1:0] stat;
    logic [14:0] word_pclk;

    // Channel 0 active, 1 reactive, 2 apparent
    assign pwr[0] = active_power;
    assign pwr[1] = reactive_power;
    assign pwr[2] = apparent_power;

    // Divided clock tick; zero field means divide by 16
    assign div_last = (s_q.div_k == `EPO_DIV_ZERO) ? `EPO_DIV_ZERO_LAST
                    : s_q.div_k - `EPO_DIV_ONE;
    assign dclk_tick = (s_q.div_cnt == div_last);
    assign word_tick = dclk_tick && (s_q.word_cnt == `EPO_WORD_LAST);

    // Bus phases
    assign access = psel && penable;
    assign commit = access && s_q.pready;
    assign addr_ok = (paddr == `EPO_ADDR_MODE) || (paddr == `EPO_ADDR_RATE)
                  || (paddr == `EPO_ADDR_DIV) || (paddr == `EPO_ADDR_STAT);

    // Reactive may not fall when the active pulse of the same word needs the
    // opposite sign on the second pin; it waits one word instead
    assign allow[0] = 1'b1;
    assign allow[1] = !(s_q.sel2 == EPO_S2_SIGN && due[0]
                      && (pwr[0][23] != pwr[1][23]));
    assign allow[2] = 1'b1;

    // Unused channels, and the reactive channel while the third pin settles, do not build up energy
    assign clear[0] = 1'b0;
    assign clear[1] = (s_q.sel3 != EPO_S3_REACTIVE) || s_q.settle3;
    assign clear[2] = (s_q.sel2 != EPO_S2_APPARENT) && (s_q.sel3 != EPO_S3_APPARENT);

    // One accumulator pulse generator per channel
    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1)
        begin : g_chan
            if (c == 2)
            begin : g_unsigned
                // Apparent power has no sign to strip
                assign mag[c] = pwr[c];
            end
            else
            begin : g_signed
                logic [23:0] neg;
                assign neg = ~pwr[c] + 24'h000001;
                // Most negative value saturates rather than wrapping to zero
                assign mag[c] = !pwr[c][23] ? {pwr[c][22:0], 1'b0}
                              : (pwr[c] == `EPO_SIGNED_MIN) ? `EPO_MAG_SAT
                              : {neg[22:0], 1'b0};
            end
            epo_pulse_gen u_gen (
                .pclk(pclk),
                .presetn(presetn),
                .word_tick(word_tick),
                .clear(clear[c]),
                .allow(allow[c]),
                .magnitude(mag[c]),
                .rate(s_q.rate),
                .due(due[c]),
                .pulse(pulse[c])
            );
        end
    endgenerate

    // Readable state
    assign stat = {s_q.cmp_sync, s_q.settle3, s_q.settle2, s_q.sign,
                   s_q.third, s_q.second, s_q.first};

    // Next state
    always_comb
    begin
        s_d = s_q;

        // Comparator pin passes two flops first
        s_d.cmp_meta = supply_threshold_compare;
        s_d.cmp_sync = s_q.cmp_meta;

        // Divider and output word counter
        s_d.div_cnt = dclk_tick ? '0 : s_q.div_cnt + `EPO_DIV_ONE;
        if (dclk_tick)
        begin
            s_d.word_cnt = s_q.word_cnt + 10'h001;
        end

        // Settling ends at a word boundary, when every pulse has ended
        if (word_tick)
        begin
            s_d.settle2 = 1'b0;
            s_d.settle3 = 1'b0;
        end

        // Sign level moves one cycle ahead of the falling pulse edges
        if (word_tick)
        begin
            if (due[0])
            begin
                s_d.sign = !pwr[0][23];
            end
            else if (due[1] && allow[1] && !clear[1])
            begin
                s_d.sign = !pwr[1][23];
            end
            if (due[1] && allow[1] && !clear[1])
            begin
                s_d.react_neg = pwr[1][23];
            end
        end

        // APB answer one cycle into the access phase
        s_d.pready = access && !s_q.pready;
        if (access && !s_q.pready)
        begin
            s_d.pslverr = !addr_ok;
            s_d.prdata = '0;
            if (!pwrite)
            begin
                case (paddr)
                    `EPO_ADDR_MODE:
                    begin
                        s_d.prdata[`EPO_SEL2_LSB+:2] = s_q.sel2;
                        s_d.prdata[`EPO_SEL3_LSB+:2] = s_q.sel3;
                    end
                    `EPO_ADDR_RATE: s_d.prdata[23:0] = s_q.rate;
                    `EPO_ADDR_DIV: s_d.prdata[3:0] = s_q.div_k;
                    `EPO_ADDR_STAT: s_d.prdata[`EPO_STAT_W-1:0] = stat;
                    default: s_d.prdata = '0;
                endcase
            end
        end
        else if (commit)
        begin
            s_d.pslverr = 1'b0;
        end

        // Writes take effect at the edge that sees pready high
        if (commit && pwrite)
        begin
            case (paddr)
                `EPO_ADDR_MODE:
                begin
                    if (pstrb[0])
                    begin
                        s_d.sel2 = epo_sel2_type'(pwdata[`EPO_SEL2_LSB+:2]);
                        s_d.sel3 = epo_sel3_type'(pwdata[`EPO_SEL3_LSB+:2]);
                        if (s_d.sel2 != s_q.sel2)
                        begin
                            s_d.settle2 = 1'b1;
                        end
                        if (s_d.sel3 != s_q.sel3)
                        begin
                            s_d.settle3 = 1'b1;
                        end
                    end
                end
                `EPO_ADDR_RATE:
                begin
                    if (pstrb[0])
                    begin
                        s_d.rate[7:0] = pwdata[7:0];
                    end
                    if (pstrb[1])
                    begin
                        s_d.rate[15:8] = pwdata[15:8];
                    end
                    if (pstrb[2])
                    begin
                        s_d.rate[23:16] = pwdata[23:16];
                    end
                end
                `EPO_ADDR_DIV:
                begin
                    if (pstrb[0])
                    begin
                        s_d.div_k = pwdata[3:0];
                    end
                end
                default: s_d.div_k = s_q.div_k;
            endcase
        end

        // First pin: active energy
        s_d.first = !pulse[0];

        // Second pin function
        case (s_q.sel2)
            EPO_S2_SIGN: s_d.second = s_d.sign;
            EPO_S2_APPARENT: s_d.second = !pulse[2];
            EPO_S2_TAMPER: s_d.second = !tamper_detected;
            default: s_d.second = 1'b1;
        endcase
        if (s_q.settle2)
        begin
            s_d.second = 1'b1;
        end

        // Third pin function
        case (s_q.sel3)
            EPO_S3_REACTIVE: s_d.third = !pulse[1];
            EPO_S3_SUPPLY: s_d.third = s_q.cmp_sync;
            EPO_S3_VSIGN: s_d.third = !line_voltage_negative;
            default: s_d.third = !pulse[2];
        endcase
        if (s_q.settle3)
        begin
            s_d.third = 1'b1;
        end

        // Helpers for the checks below
        if (s_q.first && !s_d.first)
        begin
            s_d.ticks_since = '0;
        end
        else if (word_tick && s_q.ticks_since != 2'h3)
        begin
            s_d.ticks_since = s_q.ticks_since + 2'h1;
        end
        s_d.low_cnt = s_q.first ? '0 : s_q.low_cnt + 15'h0001;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.sel2 <= EPO_S2_SIGN;
            s_q.sel3 <= EPO_S3_REACTIVE;
            s_q.rate <= `EPO_RATE_RST;
            s_q.div_k <= `EPO_DIV_RST;
            s_q.sign <= 1'b1;
            s_q.first <= 1'b1;
            s_q.second <= 1'b1;
            s_q.third <= 1'b1;
            s_q.ticks_since <= 2'h3;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign first_pulse_pin = s_q.first;
    assign second_pulse_pin = s_q.second;
    assign third_pulse_pin = s_q.third;

    // Length of one word in pclk cycles at the current ratio
    assign word_pclk = 15'({1'b0, div_last} + 15'h0001) * 15'(`EPO_WORD_LEN);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apparent_on_second;
        s_q.sel2 == EPO_S2_APPARENT && !s_q.settle2 && pulse[2];
    endsequence

    sequence apparent_on_third;
        s_q.sel3 == EPO_S3_APPARENT && !s_q.settle3 && pulse[2];
    endsequence

    sequence mode_write;
        commit && pwrite && paddr == `EPO_ADDR_MODE && pstrb[0];
    endsequence

    chk_apparent_second_pin: assert property (
        apparent_on_second |=> !second_pulse_pin)
        else $error("second pin not low during apparent pulse");

    chk_apparent_third_pin: assert property (
        apparent_on_third |=> !third_pulse_pin)
        else $error("third pin not low during apparent pulse");

    chk_pulse_spacing: assert property (
        $fell(first_pulse_pin) |-> $past(s_q.ticks_since) >= 2'h2)
        else $error("first pin pulses closer than two words");

    chk_reactive_sign_hold: assert property (
        $fell(third_pulse_pin) && $past(s_q.sel3) == EPO_S3_REACTIVE
        && $past(s_q.sel2) == EPO_S2_SIGN
        |-> $stable(second_pulse_pin) && second_pulse_pin == !s_q.react_neg)
        else $error("second pin does not hold reactive sign at third pin fall");

    chk_voltage_sign_level: assert property (
        s_q.sel3 == EPO_S3_VSIGN && !s_q.settle3
        |=> third_pulse_pin == !$past(line_voltage_negative))
        else $error("third pin does not follow voltage sign");

    chk_supply_level: assert property (
        s_q.sel3 == EPO_S3_SUPPLY && !s_q.settle3 |-> ##1 third_pulse_pin == $past(s_q.cmp_sync))
        else $error("third pin does not follow supply comparator");

    chk_pulse_width: assert property (
        $stable(s_q.div_k) ##1 ($rose(first_pulse_pin) && $stable(s_q.div_k))
        |-> $past(s_q.low_cnt) + 15'h0001 == word_pclk)
        else $error("first pin pulse is not one word long");

    chk_div_zero_ratio: assert property (
        s_q.div_k == `EPO_DIV_ZERO && $past(s_q.div_k, `EPO_DIV_ZERO_RATIO) == `EPO_DIV_ZERO
        && dclk_tick |-> $past(dclk_tick, `EPO_DIV_ZERO_RATIO))
        else $error("zero divide field does not divide by 16");

    chk_mode_settle: assert property (
        mode_write ##1 (s_q.settle2 || s_q.settle3) |=> (s_q.settle2 -> second_pulse_pin)
        && (s_q.settle3 -> third_pulse_pin))
        else $error("pin not held high after select change");

    chk_reset_reactive: assert property (
        s_q.sel3 == EPO_S3_REACTIVE && !s_q.settle3 && pulse[1] |=> !third_pulse_pin)
        else $error("reactive pulse missing on third pin");

endmodule

// File: verif/epo_pulse_counter.sv
`timescale 1ns/100ps

module epo_pulse_counter
(
    // Clock and tally clear
    input wire logic pclk,
    input wire logic clear,
    // Observed pins
    input wire logic first_pulse_pin,
    input wire logic second_pulse_pin,
    input wire logic third_pulse_pin,
    // Tallies per pin
    output int falls [3],
    output int low_len [3],
    output int min_gap [3],
    output logic sign_at [3]
);
    logic [2:0] pins;
    logic [2:0] pins_q = 3'h7;
    int run [3];
    int gap [3];

    assign pins = {third_pulse_pin, second_pulse_pin, first_pulse_pin};

    // Passive meter: sampled mid-cycle so pin updates never race the count
    always @(negedge pclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            gap[i] = gap[i] + 1;
            if (!pins[i])
                run[i] = run[i] + 1;
            if (pins_q[i] && !pins[i])
            begin
                falls[i] = falls[i] + 1;
                if (falls[i] > 1 && gap[i] < min_gap[i])
                    min_gap[i] = gap[i];
                gap[i] = 0;
                run[i] = 1;
                sign_at[i] = second_pulse_pin;
            end
            if (!pins_q[i] && pins[i])
                low_len[i] = run[i];
            if (clear)
            begin
                falls[i] = 0;
                min_gap[i] = 1000000;
                low_len[i] = 0;
            end
        end
        pins_q = pins;
    end
endmodule

// File: verif/energy_pulse_output_select_tb.sv
`timescale 1ns/100ps
`include "epo_regs.svh"

module energy_pulse_output_select_tb
    import epo_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr;
    logic [23:0] active_power, reactive_power, apparent_power, v;
    logic line_voltage_negative, tamper_detected, supply_threshold_compare;
    logic first_pulse_pin, second_pulse_pin, third_pulse_pin;
    logic sign_at [3];
    int falls [3], low_len [3], min_gap [3];
    int seed, fail_count, check_count, cycles, p;
    logic [64:0] exp_q [$];
    logic [64:0] note;
    // Apparent cases: rate per word is power times scale over two, 16 words each
    logic [23:0] app_t [3] = '{24'h800000, 24'hFFFFFF, 24'hFFFFFF};
    logic [23:0] rate_t [3] = '{24'hFFFFFF, 24'h800000, 24'hFFFFFF};
    int lo_t [3] = '{3, 3, 7};
    int hi_t [3] = '{5, 5, 8};

    epo_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .active_power(active_power),
        .reactive_power(reactive_power), .apparent_power(apparent_power),
        .line_voltage_negative(line_voltage_negative), .tamper_detected(tamper_detected),
        .supply_threshold_compare(supply_threshold_compare),
        .first_pulse_pin(first_pulse_pin), .second_pulse_pin(second_pulse_pin),
        .third_pulse_pin(third_pulse_pin));

    epo_pulse_counter u_cnt (.pclk(pclk), .clear(clr), .first_pulse_pin(first_pulse_pin),
        .second_pulse_pin(second_pulse_pin), .third_pulse_pin(third_pulse_pin),
        .falls(falls), .low_len(low_len), .min_gap(min_gap), .sign_at(sign_at));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the expected answer goes to the queue, mask zero skips data
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] mask, input logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back({mask, err, d});
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so a following call never drives psel twice in one step
        @(posedge pclk);
    endtask

    // Clear the tallies, then let whole output words pass
    task automatic run_words(input int n);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n * `EPO_WORD_LEN + 4) @(posedge pclk);
    endtask

    // Align to a pulse fall so the next word tick is a full word away
    task automatic wait_fall(input int i);
        int c;
        int n;
        c = falls[i];
        n = 0;
        while (falls[i] == c && n < 5000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000)
            fail_count++;
    endtask

    // Answer checker: oldest queued note against the completing transfer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            check("prdata", prdata & note[64:33], note[31:0] & note[64:33]);
        end
    end

    // Hang guard well above the planned run length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles > 95000)
        begin
            fail_count++;
            print_verdict;
        end
    end

    initial
    begin
        seed = 84977;
        {pclk, presetn, psel, penable, pwrite, clr} = 6'h0;
        {paddr, pwdata, pstrb} = {12'h0, 32'h0, 4'hF};
        {active_power, reactive_power, apparent_power} = 72'h0;
        {line_voltage_negative, tamper_detected, supply_threshold_compare} = 3'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped place, zero divide field
        apb(1'b0, `EPO_ADDR_MODE, 32'h0, 32'hF, 1'b0);
        apb(1'b0, `EPO_ADDR_RATE, {8'h0, `EPO_RATE_RST}, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, `EPO_ADDR_DIV, 32'h1, 32'hF, 1'b0);
        apb(1'b0, `EPO_ADDR_STAT, 32'h7, 32'h7, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 12'h010, 32'h5, 32'h0, 1'b1);
        apb(1'b1, `EPO_ADDR_DIV, 32'h0, 32'h0, 1'b0);
        // Long enough for two divide-by-16 ticks
        repeat (40) @(posedge pclk);
        apb(1'b0, `EPO_ADDR_DIV, 32'h0, 32'hF, 1'b0);
        apb(1'b1, `EPO_ADDR_DIV, 32'h1, 32'h0, 1'b0);
        apb(1'b1, `EPO_ADDR_RATE, 32'hFFFFFF, 32'h0, 1'b0);
        // Active then reactive, each sign, near full scale
        for (int c = 0; c < 4; c++)
        begin
            v = {16'h7FFF, 8'($random(seed))};
            if (c[0])
                v = -v;
            active_power <= (c < 2) ? v : 24'h0;
            reactive_power <= (c < 2) ? 24'h0 : v;
            run_words(6);
            p = (c < 2) ? 0 : 2;
            check("pulse_count", {31'h0, falls[p] >= 2}, 32'h1);
            check("pulse_width", low_len[p], `EPO_WORD_LEN);
            check("sign_level", {31'h0, sign_at[p]}, {31'h0, !c[0]});
        end
        // Apparent pulses on second and third pins together
        wait_fall(2);
        apb(1'b1, `EPO_ADDR_MODE, {28'h0, EPO_S3_APPARENT, EPO_S2_APPARENT}, 32'h0, 1'b0);
        reactive_power <= 24'h0;
        for (int c = 0; c < 3; c++)
        begin
            apparent_power <= app_t[c];
            apb(1'b1, `EPO_ADDR_RATE, {8'h0, rate_t[c]}, 32'h0, 1'b0);
            run_words(16);
            for (int i = 1; i < 3; i++)
            begin
                check("app_count", {31'h0, falls[i] >= lo_t[c] && falls[i] <= hi_t[c]}, 1);
                check("app_gap", {31'h0, min_gap[i] >= 2 * `EPO_WORD_LEN}, 32'h1);
                check("app_pin", {31'h0, falls[i] > 0}, 32'h1);
            end
        end
        // Level modes: pins rest high after the change until the next word
        wait_fall(2);
        line_voltage_negative <= 1'b1;
        tamper_detected <= 1'b1;
        apb(1'b1, `EPO_ADDR_MODE, {28'h0, EPO_S3_VSIGN, EPO_S2_TAMPER}, 32'h0, 1'b0);
        apb(1'b0, `EPO_ADDR_STAT, 32'h36, 32'h36, 1'b0);
        repeat (1100) @(posedge pclk);
        repeat (8)
        begin
            line_voltage_negative <= 1'($random(seed));
            tamper_detected <= 1'($random(seed));
            repeat (4) @(posedge pclk);
            check("vsign", {31'h0, third_pulse_pin}, {31'h0, !line_voltage_negative});
            check("tamper", {31'h0, second_pulse_pin}, {31'h0, !tamper_detected});
        end
        apb(1'b1, `EPO_ADDR_MODE, {28'h0, EPO_S3_SUPPLY, EPO_S2_RESERVED}, 32'h0, 1'b0);
        repeat (1100) @(posedge pclk);
        repeat (8)
        begin
            supply_threshold_compare <= 1'($random(seed));
            repeat (5) @(posedge pclk);
            check("supply", {31'h0, third_pulse_pin}, {31'h0, supply_threshold_compare});
            check("reserved", {31'h0, second_pulse_pin}, 32'h1);
        end
        print_verdict;
    end
endmodule
